// ---- core/efs_status_capture.sv ----
// per-frame transmit and receive status capture with apb registers
`default_nettype none
// Contract
// - too many collisions: flag, halt, error irq
// - fifo empty mid-frame: flag, halt, error irq
// - oversize unless allowed: flag, truncate, halt
// - oversize unless allowed: descriptor buffer length zero
// - deferred flag, never for late collisions
// - crc mismatch: flag, halt; never when inserting
// - four-bit transmit collision count
// - rx status loads with rx done flag
// - rx status low half to descriptor
// - eleven-bit receive byte length
// - carrier event since last status reported
// - short event flag for too-short receive
// - rx good: crc ok, no symbol errors
// - broadcast destination flag
// - multicast destination flag
// - one to seven dribble bits flagged
// - tx status loads with done, descriptor copy
// - tx good when delivered without problem
module efs_status_capture (
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  input  wire efs_pkg::efs_tx_report_type txReport,
  input  wire efs_pkg::efs_rx_report_type rxReport,
  input  wire logic                      phyRxErrorPin,
  input  wire logic                      phyRxValidPin,
  input  wire logic [3:0]                phyRxData,
  output logic                           txHalted,
  output logic                           txTruncate,
  output logic                           txDescWrite,
  output logic [15:0]                    txDescStatus,
  output logic                           txDescLenWrite,
  output logic [10:0]                    txDescLength,
  output logic                           rxDescWrite,
  output logic [15:0]                    rxDescStatus,
  output logic                           irq
);
  // ****************************************
  // state
  // ****************************************
  logic [31:0]               controlReg;
  logic [31:0]               txStatusReg;
  logic [31:0]               txStatusNext;
  logic [31:0]               rxStatusReg;
  logic [31:0]               rxStatusNext;
  logic [2:0]                intStatusReg;
  logic [2:0]                intEnableReg;
  logic                      carrierPendingReg;
  efs_pkg::efs_tx_state_type txStateReg;
  efs_pkg::efs_tx_state_type txStateNext;

  logic        oversizeAllowSetting;
  logic        checksumInsertEnable;
  logic [3:0]  retryLimit;
  logic [15:0] maxFrameLength;
  logic        txAbortTooManyCollisions;
  logic        txAbortFifoEmpty;
  logic        txAbortOversize;
  logic        txDeferredFlag;
  logic        txChecksumMismatch;
  logic [3:0]  txCollisionCount;
  logic        txGoodFlag;
  logic        txAbort;
  logic        carrierEvent;
  logic        restartReq;
  logic [2:0]  intSet;
  logic [2:0]  intClear;
  logic        setupPhase;
  logic        writeAccess;

  // saturate a collision tally into the four-bit field
  function automatic logic [3:0] sat_count(input logic [4:0] n);
    sat_count = n[4] ? efs_pkg::EFS_COLL_MAX : n[3:0];
  endfunction : sat_count

  // full-word write match for a register address
  function automatic logic wr_hit(input logic [31:0] a,
                                  input logic [31:0] target);
    wr_hit = (a == target);
  endfunction : wr_hit

  // ****************************************
  // apb slave
  // ****************************************
  // zero wait states: data is prepared during setup
  assign pready      = 1'b1;
  assign setupPhase  = psel && !penable;
  assign writeAccess = psel && penable && pwrite;
  assign oversizeAllowSetting = controlReg[efs_pkg::EFS_CTL_ALLOW_OVERSIZE];
  assign checksumInsertEnable = controlReg[efs_pkg::EFS_CTL_CRC_INSERT];
  assign retryLimit     = controlReg[efs_pkg::EFS_CTL_RETRY_LSB +: 4];
  assign maxFrameLength = controlReg[efs_pkg::EFS_CTL_MAXLEN_LSB +: 16];
  assign restartReq = writeAccess &&
                      wr_hit(paddr, efs_pkg::EFS_ADDR_CONTROL) &&
                      pwdata[efs_pkg::EFS_CTL_TX_RESTART] && pstrb[0];
  assign intClear = (writeAccess &&
                     wr_hit(paddr, efs_pkg::EFS_ADDR_INT_CLEAR) &&
                     pstrb[0]) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata  <= efs_pkg::EFS_RESET_VALUE;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= 1'b0;
      prdata  <= efs_pkg::EFS_RESET_VALUE;
      case (paddr)
        efs_pkg::EFS_ADDR_TX_STATUS: begin
          prdata  <= txStatusReg;
          pslverr <= pwrite;
        end
        efs_pkg::EFS_ADDR_RX_STATUS: begin
          prdata  <= rxStatusReg;
          pslverr <= pwrite;
        end
        efs_pkg::EFS_ADDR_CONTROL: begin
          prdata <= controlReg;
        end
        efs_pkg::EFS_ADDR_INT_STATUS: begin
          prdata  <= {29'h0000_0000, intStatusReg};
          pslverr <= pwrite;
        end
        efs_pkg::EFS_ADDR_INT_CLEAR: begin
          pslverr <= !pwrite;
        end
        efs_pkg::EFS_ADDR_INT_ENABLE: begin
          prdata <= {29'h0000_0000, intEnableReg};
        end
        default: begin
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // restart bit is a strobe and never stored
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      controlReg <= efs_pkg::EFS_CONTROL_RESET;
    end else if (writeAccess && wr_hit(paddr, efs_pkg::EFS_ADDR_CONTROL)) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          controlReg[b*8 +: 8] <= pwdata[b*8 +: 8];
        end
      end
      controlReg[efs_pkg::EFS_CTL_TX_RESTART] <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      intEnableReg <= 3'h0;
    end else if (writeAccess &&
                 wr_hit(paddr, efs_pkg::EFS_ADDR_INT_ENABLE) && pstrb[0]) begin
      intEnableReg <= pwdata[2:0];
    end
  end

  // ****************************************
  // transmit status
  // ****************************************
  assign txAbortTooManyCollisions =
    txReport.collisions > {1'b0, retryLimit};
  assign txAbortFifoEmpty = txReport.fifoEmpty;
  assign txAbortOversize  = !oversizeAllowSetting &&
                            (txReport.lengthBytes > maxFrameLength);
  // inserted crc is ours, so no mismatch can be blamed
  assign txChecksumMismatch = !checksumInsertEnable &&
    (txReport.crcAppended != txReport.crcComputed);
  assign txDeferredFlag = !txReport.lateCollision &&
    (((txReport.deferAttempts != 4'h0) && !txReport.deferExcess) ||
     txReport.deferByCollision);
  assign txCollisionCount = sat_count(txReport.collisions);
  assign txAbort = txAbortTooManyCollisions || txAbortFifoEmpty ||
                   txAbortOversize || txChecksumMismatch;
  assign txGoodFlag = txReport.delivered && !txAbort;

  always_comb begin
    txStatusNext = efs_pkg::EFS_RESET_VALUE;
    txStatusNext[efs_pkg::EFS_TX_GOOD]       = txGoodFlag;
    txStatusNext[efs_pkg::EFS_TX_EXC_COLL]   = txAbortTooManyCollisions;
    txStatusNext[efs_pkg::EFS_TX_FIFO_EMPTY] = txAbortFifoEmpty;
    txStatusNext[efs_pkg::EFS_TX_OVERSIZE]   = txAbortOversize;
    txStatusNext[efs_pkg::EFS_TX_DEFERRED]   = txDeferredFlag;
    txStatusNext[efs_pkg::EFS_TX_CRC_BAD]    = txChecksumMismatch;
    txStatusNext[efs_pkg::EFS_TX_COLL_LSB +: 4] = txCollisionCount;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txStatusReg <= efs_pkg::EFS_RESET_VALUE;
    end else if (txReport.frameDone && txStateReg == efs_pkg::EFS_TX_RUN) begin
      txStatusReg <= txStatusNext;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txDescWrite    <= 1'b0;
      txDescStatus   <= 16'h0000;
      txDescLenWrite <= 1'b0;
      txDescLength   <= efs_pkg::EFS_TX_LEN_ZERO;
      txTruncate     <= 1'b0;
    end else begin
      txDescWrite    <= txReport.frameDone &&
                        txStateReg == efs_pkg::EFS_TX_RUN;
      txDescStatus   <= txStatusNext[15:0];
      txDescLenWrite <= txReport.frameDone && txAbortOversize &&
                        txStateReg == efs_pkg::EFS_TX_RUN;
      txDescLength   <= efs_pkg::EFS_TX_LEN_ZERO;
      txTruncate     <= txReport.frameDone && txAbortOversize &&
                        txStateReg == efs_pkg::EFS_TX_RUN;
    end
  end

  // ****************************************
  // transmit halt
  // ****************************************
  // frames reported while halted are dropped, not recorded
  always_comb begin
    txStateNext = txStateReg;
    case (txStateReg)
      efs_pkg::EFS_TX_RUN: begin
        if (txReport.frameDone && txAbort) begin
          txStateNext = efs_pkg::EFS_TX_HALTED;
        end
      end
      efs_pkg::EFS_TX_HALTED: begin
        if (restartReq) begin
          txStateNext = efs_pkg::EFS_TX_RUN;
        end
      end
      default: begin
        txStateNext = efs_pkg::EFS_TX_HALTED;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txStateReg <= efs_pkg::EFS_TX_RUN;
    end else begin
      txStateReg <= txStateNext;
    end
  end

  assign txHalted = (txStateReg == efs_pkg::EFS_TX_HALTED);

  // ****************************************
  // receive status
  // ****************************************
  assign carrierEvent = phyRxErrorPin && !phyRxValidPin &&
                        (phyRxData == efs_pkg::EFS_CARRIER_NIBBLE);

  always_comb begin
    rxStatusNext = efs_pkg::EFS_RESET_VALUE;
    rxStatusNext[efs_pkg::EFS_RX_LEN_LSB +: 11] = rxReport.lengthBytes;
    rxStatusNext[efs_pkg::EFS_RX_CARRIER] =
      carrierPendingReg || carrierEvent;
    rxStatusNext[efs_pkg::EFS_RX_SHORT] = rxReport.tooShort;
    rxStatusNext[efs_pkg::EFS_RX_GOOD] =
      rxReport.crcOk && !rxReport.symbolError;
    rxStatusNext[efs_pkg::EFS_RX_BROADCAST] = rxReport.crcOk &&
      (rxReport.destAddr == efs_pkg::EFS_BROADCAST);
    rxStatusNext[efs_pkg::EFS_RX_MULTICAST] = rxReport.crcOk &&
      rxReport.destAddr[efs_pkg::EFS_DEST_GROUP] &&
      (rxReport.destAddr != efs_pkg::EFS_BROADCAST);
    // meaningless on the reduced interface; software ignores it there
    rxStatusNext[efs_pkg::EFS_RX_DRIBBLE] =
      (rxReport.extraBits != 3'h0);
  end

  // an event in the reporting cycle is kept with this frame
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      carrierPendingReg <= 1'b0;
    end else if (rxReport.frameDone) begin
      carrierPendingReg <= 1'b0;
    end else if (carrierEvent) begin
      carrierPendingReg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxStatusReg  <= efs_pkg::EFS_RESET_VALUE;
      rxDescWrite  <= 1'b0;
      rxDescStatus <= 16'h0000;
    end else begin
      rxDescWrite <= rxReport.frameDone;
      if (rxReport.frameDone) begin
        rxStatusReg  <= rxStatusNext;
        rxDescStatus <= rxStatusNext[15:0];
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_comb begin
    intSet = 3'h0;
    intSet[efs_pkg::EFS_INT_TX_DONE] =
      txReport.frameDone && txStateReg == efs_pkg::EFS_TX_RUN;
    intSet[efs_pkg::EFS_INT_TX_ERROR] =
      txReport.frameDone && txAbort &&
      txStateReg == efs_pkg::EFS_TX_RUN;
    intSet[efs_pkg::EFS_INT_RX_DONE] = rxReport.frameDone;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      intStatusReg <= 3'h0;
    end else begin
      intStatusReg <= ((intStatusReg & ~intClear) | intSet) &
                      efs_pkg::EFS_INT_MASK;
    end
  end

  assign irq = |(intStatusReg & intEnableReg);

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence txAbortDone;
    txReport.frameDone && txAbort && txStateReg == efs_pkg::EFS_TX_RUN;
  endsequence
  sequence txHaltRaised;
    txHalted && intStatusReg[efs_pkg::EFS_INT_TX_ERROR];
  endsequence

  AST_EXC_COLL: assert property (txAbortDone and
    (txReport.collisions > {1'b0, retryLimit}) |=>
    txStatusReg[efs_pkg::EFS_TX_EXC_COLL] ##0 txHaltRaised)
    else $error("collision abort not recorded");
  AST_FIFO_EMPTY: assert property (txAbortDone and
    txReport.fifoEmpty |=> txStatusReg[efs_pkg::EFS_TX_FIFO_EMPTY]
    ##0 txHaltRaised)
    else $error("underrun abort not recorded");
  AST_OVERSIZE: assert property (txReport.frameDone &&
    oversizeAllowSetting |=> !txStatusReg[efs_pkg::EFS_TX_OVERSIZE])
    else $error("oversize flagged while allowed");
  AST_LEN_ZERO: assert property (txAbortDone and
    txAbortOversize |=> txDescLenWrite &&
    txDescLength == efs_pkg::EFS_TX_LEN_ZERO
    && txTruncate)
    else $error("oversize length not cleared");
  AST_DEFER_LATE: assert property (txReport.frameDone &&
    txReport.lateCollision && txStateReg == efs_pkg::EFS_TX_RUN
    |=> !txStatusReg[efs_pkg::EFS_TX_DEFERRED])
    else $error("deferred set on late collision");
  AST_CRC_INSERT: assert property (txReport.frameDone &&
    checksumInsertEnable && txStateReg == efs_pkg::EFS_TX_RUN
    |=> !txStatusReg[efs_pkg::EFS_TX_CRC_BAD])
    else $error("crc error while inserting");
  AST_HALT_HOLDS: assert property (txHalted && !restartReq
    |=> txHalted)
    else $error("halt released without restart");
  AST_COLL_COUNT: assert property (txReport.frameDone &&
    txStateReg == efs_pkg::EFS_TX_RUN |=>
    txStatusReg[3:0] == sat_count($past(txReport.collisions)))
    else $error("collision count wrong");
  AST_RX_LOAD: assert property (rxReport.frameDone |=>
    rxStatusReg == $past(rxStatusNext) &&
    intStatusReg[efs_pkg::EFS_INT_RX_DONE])
    else $error("rx status not loaded with flag");
  AST_RX_DESC: assert property (rxDescWrite |->
    rxDescStatus == rxStatusReg[15:0])
    else $error("rx descriptor status mismatch");
  AST_RX_LEN: assert property (rxReport.frameDone |=>
    rxStatusReg[26:16] == $past(rxReport.lengthBytes))
    else $error("rx length wrong");
  AST_CARRIER: assert property (carrierEvent &&
    !rxReport.frameDone ##1 rxReport.frameDone |=>
    rxStatusReg[efs_pkg::EFS_RX_CARRIER])
    else $error("carrier event lost");
  AST_RX_GOOD: assert property (rxReport.frameDone &&
    rxReport.symbolError |=> !rxStatusReg[efs_pkg::EFS_RX_GOOD])
    else $error("rx good with symbol error");
  AST_TX_GOOD: assert property (txAbortDone |=>
    !txStatusReg[efs_pkg::EFS_TX_GOOD] && txDescWrite)
    else $error("tx good on aborted frame");
endmodule : efs_status_capture
`default_nettype wire

// ---- shared/efs_pkg.sv ----
// constants, register map and carrier types for frame status capture
`default_nettype none
package efs_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [31:0] EFS_ADDR_TX_STATUS  = 32'hA060_0018;
  localparam logic [31:0] EFS_ADDR_RX_STATUS  = 32'hA060_001C;
  localparam logic [31:0] EFS_ADDR_CONTROL    = 32'hA060_0100;
  localparam logic [31:0] EFS_ADDR_INT_STATUS = 32'hA060_0104;
  localparam logic [31:0] EFS_ADDR_INT_CLEAR  = 32'hA060_0108;
  localparam logic [31:0] EFS_ADDR_INT_ENABLE = 32'hA060_010C;
  localparam logic [31:0] EFS_RESET_VALUE     = 32'h0000_0000;
  localparam logic [31:0] EFS_CONTROL_RESET   = 32'h0600_0F00;
  // ****************************************
  // control register fields
  // ****************************************
  localparam int EFS_CTL_ALLOW_OVERSIZE = 0;
  localparam int EFS_CTL_CRC_INSERT     = 1;
  localparam int EFS_CTL_TX_RESTART     = 2;
  localparam int EFS_CTL_RETRY_LSB      = 8;
  localparam int EFS_CTL_MAXLEN_LSB     = 16;
  // ****************************************
  // transmit status fields
  // ****************************************
  localparam int EFS_TX_GOOD       = 15;
  localparam int EFS_TX_EXC_COLL   = 10;
  localparam int EFS_TX_FIFO_EMPTY = 9;
  localparam int EFS_TX_OVERSIZE   = 8;
  localparam int EFS_TX_DEFERRED   = 6;
  localparam int EFS_TX_CRC_BAD    = 5;
  localparam int EFS_TX_COLL_LSB   = 0;
  // ****************************************
  // receive status fields
  // ****************************************
  localparam int EFS_RX_LEN_LSB    = 16;
  localparam int EFS_RX_CARRIER    = 15;
  localparam int EFS_RX_SHORT      = 14;
  localparam int EFS_RX_GOOD       = 13;
  localparam int EFS_RX_BROADCAST  = 12;
  localparam int EFS_RX_MULTICAST  = 11;
  localparam int EFS_RX_DRIBBLE    = 9;
  localparam int EFS_DEST_GROUP    = 40;
  // ****************************************
  // interrupt bits and misc values
  // ****************************************
  localparam int EFS_INT_TX_DONE   = 0;
  localparam int EFS_INT_TX_ERROR  = 1;
  localparam int EFS_INT_RX_DONE   = 2;
  localparam logic [2:0]  EFS_INT_MASK       = 3'h7;
  localparam logic [3:0]  EFS_CARRIER_NIBBLE = 4'hE;
  localparam logic [3:0]  EFS_COLL_MAX       = 4'hF;
  localparam logic [10:0] EFS_TX_LEN_ZERO    = 11'h000;
  localparam logic [47:0] EFS_BROADCAST      = 48'hFFFF_FFFF_FFFF;

  typedef enum logic {
    EFS_TX_RUN    = 1'b0,
    EFS_TX_HALTED = 1'b1
  } efs_tx_state_type;

  typedef struct packed {
    logic        frameDone;
    logic        delivered;
    logic        fifoEmpty;
    logic [15:0] lengthBytes;
    logic [31:0] crcAppended;
    logic [31:0] crcComputed;
    logic [4:0]  collisions;
    logic [3:0]  deferAttempts;
    logic        deferExcess;
    logic        deferByCollision;
    logic        lateCollision;
  } efs_tx_report_type;

  typedef struct packed {
    logic        frameDone;
    logic [10:0] lengthBytes;
    logic        crcOk;
    logic        symbolError;
    logic        tooShort;
    logic [47:0] destAddr;
    logic [2:0]  extraBits;
  } efs_rx_report_type;
endpackage : efs_pkg
`default_nettype wire

// ---- tb/efs_phy_model.sv ----
// media-side partner: frame reports and receive pins
`default_nettype none
module efs_phy_model (
  input  wire logic                   clock,
  output var efs_pkg::efs_tx_report_type txReport,
  output var efs_pkg::efs_rx_report_type rxReport,
  output logic                        phyRxErrorPin,
  output logic                        phyRxValidPin,
  output logic [3:0]                  phyRxData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic carrierNow;
  initial begin
    txReport = '0;
    rxReport = '0;
    carrierNow = 1'b0;
    phyRxErrorPin = 1'b0;
    phyRxValidPin = 1'b0;
    phyRxData = 4'h5;
  end
  // idle nibble inverts every cycle (5/a until a carrier, then 1/e) so a stale value never looks settled
  always @(posedge clock) begin
    phyRxErrorPin <= carrierNow;
    phyRxValidPin <= 1'b0;
    phyRxData     <= carrierNow ? efs_pkg::EFS_CARRIER_NIBBLE : ~phyRxData;
  end
  task automatic carrier;
    @(posedge clock);
    carrierNow <= 1'b1;
    @(posedge clock);
    carrierNow <= 1'b0;
  endtask : carrier
  task automatic send_tx(input efs_pkg::efs_tx_report_type r);
    @(posedge clock);
    txReport <= r;
    @(posedge clock);
    txReport.frameDone <= 1'b0;
  endtask : send_tx
  task automatic send_rx(input efs_pkg::efs_rx_report_type r);
    @(posedge clock);
    rxReport <= r;
    @(posedge clock);
    rxReport.frameDone <= 1'b0;
  endtask : send_rx
endmodule : efs_phy_model
`default_nettype wire

// ---- tb/test_efs_status_capture.sv ----
// self-checking bench for frame status capture
`default_nettype none
module test_efs_status_capture;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, txHalted;
  logic txTruncate, txDescWrite, txDescLenWrite, rxDescWrite, irq;
  logic phyRxErrorPin, phyRxValidPin, ah, bc;
  logic [31:0] paddr, pwdata, prdata, e;
  logic [3:0] pstrb, phyRxData;
  logic [15:0] txDescStatus, rxDescStatus;
  logic [10:0] txDescLength;
  efs_pkg::efs_tx_report_type txReport, r;
  efs_pkg::efs_rx_report_type rxReport, rr;
  logic [32:0] apbQ [$];
  logic [15:0] txQ [$];
  logic [15:0] rxQ [$];
  logic [15:0] txExp [7] = '{16'h8043, 16'h8003, 16'h044F, 16'h0243,
                             16'h0143, 16'h0023, 16'h8043};
  int n_mismatch = 0;
  int num_checks = 0;
  integer seed = 32'h5fe6_f491;
  efs_status_capture efs_status_capture_inst (.clock(clock),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .txReport(txReport),
    .rxReport(rxReport), .phyRxErrorPin(phyRxErrorPin),
    .phyRxValidPin(phyRxValidPin), .phyRxData(phyRxData),
    .txHalted(txHalted), .txTruncate(txTruncate),
    .txDescWrite(txDescWrite), .txDescStatus(txDescStatus),
    .txDescLenWrite(txDescLenWrite), .txDescLength(txDescLength),
    .rxDescWrite(rxDescWrite), .rxDescStatus(rxDescStatus), .irq(irq));
  efs_phy_model phy_inst (.clock(clock), .txReport(txReport),
    .rxReport(rxReport), .phyRxErrorPin(phyRxErrorPin),
    .phyRxValidPin(phyRxValidPin), .phyRxData(phyRxData));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [32:0] ex, input logic [32:0] ac);
    num_checks++;
    if (ex !== ac) begin
      n_mismatch++;
      $display("Error at %0t: expected %h got %h", $time, ex, ac);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [31:0] a, input logic [32:0] ex);
    apbQ.push_back(ex);
    apb(1'b0, a, $random(seed));
  endtask : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic err = 1'b0);
    apbQ.push_back({err, 32'h0000_0000});
    apb(1'b1, a, d);
  endtask : wr
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // results are checked at the edge that carries them
  always @(posedge clock) begin
    if (psel && penable && pready)
      chk(apbQ.pop_front(), {pslverr, pwrite ? 32'h0000_0000 : prdata});
    if (txDescWrite)
      chk(txQ.pop_front(), txDescStatus);
    if (rxDescWrite)
      chk(rxQ.pop_front(), rxDescStatus);
    if (txDescLenWrite)
      chk(12'h800, {txTruncate, txDescLength});
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    rd(efs_pkg::EFS_ADDR_TX_STATUS, 33'h0);
    rd(efs_pkg::EFS_ADDR_RX_STATUS, 33'h0);
    rd(efs_pkg::EFS_ADDR_CONTROL, 33'h0_0600_0F00);
    rd(32'hA060_0200, 33'h1_0000_0000);
    rd(efs_pkg::EFS_ADDR_INT_CLEAR, 33'h1_0000_0000);
    wr(efs_pkg::EFS_ADDR_INT_ENABLE, 32'h0000_0007);
    for (int i = 0; i < 7; i++) begin
      ah = (i >= 2 && i <= 5);
      r = '0;
      r.frameDone = 1'b1;
      r.delivered = 1'b1;
      r.lengthBytes = (i == 4 || i == 6) ? 16'h0601 : 16'h0040;
      r.collisions = (i == 2) ? 5'd16 : 5'd3;
      r.deferAttempts = (i == 3) ? 4'd0 : 4'd1;
      r.deferByCollision = (i == 3);
      r.deferExcess = (i == 5);
      r.lateCollision = (i == 1);
      r.fifoEmpty = (i == 3);
      r.crcAppended = (i >= 5);
      if (i == 6)
        wr(efs_pkg::EFS_ADDR_CONTROL, 32'h0600_0F03);
      txQ.push_back(txExp[i]);
      phy_inst.send_tx(r);
      @(negedge clock);
      chk(ah, txHalted);
      chk(1, irq);
      rd(efs_pkg::EFS_ADDR_TX_STATUS, txExp[i]);
      rd(efs_pkg::EFS_ADDR_INT_STATUS, {ah, 1'b1});
      if (ah) begin
        r.collisions = 5'd1;
        phy_inst.send_tx(r);
        rd(efs_pkg::EFS_ADDR_TX_STATUS, txExp[i]);
      end
      wr(efs_pkg::EFS_ADDR_CONTROL, 32'h0600_0F04);
      wr(efs_pkg::EFS_ADDR_INT_CLEAR, 32'h0000_0007);
      $display("tx case %0d done", i);
    end
    rd(efs_pkg::EFS_ADDR_CONTROL, 33'h0_0600_0F00);
    for (int j = 0; j < 8; j++) begin
      rr = '0;
      rr.frameDone = 1'b1;
      rr.lengthBytes = 11'($random(seed));
      {rr.crcOk, rr.symbolError, rr.tooShort} = 3'($random(seed));
      rr.extraBits = 3'($random(seed));
      rr.destAddr = {7'h00, j[0], 40'($random(seed))};
      if (j == 2 || j == 5)
        rr.destAddr = efs_pkg::EFS_BROADCAST;
      bc = (j == 2 || j == 5);
      e = {5'h00, rr.lengthBytes, j == 3, rr.tooShort,
           rr.crcOk & ~rr.symbolError, rr.crcOk & bc,
           rr.crcOk & rr.destAddr[40] & ~bc, 1'b0, rr.extraBits != 0, 9'h0};
      if (j == 3)
        phy_inst.carrier();
      rxQ.push_back(e[15:0]);
      phy_inst.send_rx(rr);
      rd(efs_pkg::EFS_ADDR_RX_STATUS,
         e);
      $display("rx frame %0d done", j);
    end
    wr(efs_pkg::EFS_ADDR_RX_STATUS, 32'hFFFF_FFFF, 1'b1);
    rd(efs_pkg::EFS_ADDR_RX_STATUS, e);
    wr(efs_pkg::EFS_ADDR_INT_CLEAR, 32'h0000_0007);
    wr(efs_pkg::EFS_ADDR_INT_ENABLE, 32'h0000_0000);
    rxQ.push_back(e[15:0]);
    phy_inst.send_rx(rr);
    @(negedge clock);
    chk(0, irq);
    rd(efs_pkg::EFS_ADDR_INT_STATUS, 33'h4);
    wr(efs_pkg::EFS_ADDR_INT_ENABLE, 32'h0000_0004);
    @(negedge clock);
    chk(1, irq);
    wr(efs_pkg::EFS_ADDR_INT_CLEAR, 32'h0000_0004);
    @(negedge clock);
    chk(0, irq);
    $display("interrupt test done");
    finish_test();
  end
endmodule : test_efs_status_capture
`default_nettype wire
